//--- include/uplm_pkg.sv
package uplm_pkg;
  localparam int NUM_U2_PORTS = 3;
  localparam int HS_UNIT_MBPS = 480;
  localparam int FLS_BUS_MBPS = 12;
  localparam int SYNC_STAGES = 3;
  localparam logic [1:0] SPD_RST = 2'h0;

  // usb 2.0 attach speed
  typedef enum logic [1:0] {
    UPLM_SPD_NONE = 2'h0,
    UPLM_SPD_LS = 2'h1,
    UPLM_SPD_FS = 2'h2,
    UPLM_SPD_HS = 2'h3
  } uplm_spd_t;

  // usb 2.0 link power, gray along on-l1-l2
  typedef enum logic [1:0] {
    UPLM_L0 = 2'h0,
    UPLM_L1 = 2'h1,
    UPLM_L2 = 2'h3
  } uplm_lpm_t;

  // superspeed link power, gray along u0-u1-u2-u3
  typedef enum logic [1:0] {
    UPLM_U0 = 2'h0,
    UPLM_U1 = 2'h1,
    UPLM_U2 = 2'h3,
    UPLM_U3 = 2'h2
  } uplm_upm_t;

  // per-port attach report from the phy side
  typedef struct packed {
    logic attached;
    logic is_usb2;
    logic low_speed;
  } uplm_attach_t;

  // wake sources
  typedef struct packed {
    logic remote_wake;
    logic connect;
    logic disconnect;
    logic overcurrent;
  } uplm_wake_t;
endpackage

//--- src/uplm_link_manager.sv
`timescale 1ns/1ps
// Overview of operation
// - each usb 2.0 port picks high speed for a 2.0 peer, else full or low.
// - every high-speed port owns one dedicated 480 Mb/s bandwidth unit.
// - all full/low-speed ports share one 12 Mb/s bus instance.
// - usb 2.0 links support L1 sleep and L2 suspend.
// - the superspeed link supports U1, U2 and U3 suspend.
// - remote wake, connect, disconnect and overcurrent wake in any state.
// - the superspeed port runs at 5 Gbps gen 1 or 10 Gbps gen 2.
// - revision 3.1 superspeed is offered only in the host role.
// - in the device role superspeed follows revision 3.0 only.
// - usb 2.0 ports work as host or device and run charger detection.
// - as host, 3.1, 2.0 and 1.1 transactions are scheduled natively.
module uplm_link_manager #(
  parameter int PORTS = uplm_pkg::NUM_U2_PORTS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire uplm_pkg::uplm_attach_t [PORTS-1:0] attach_i,
  input wire logic [PORTS-1:0] l2_lpm_req_i,
  input wire logic [PORTS-1:0] l2_suspend_req_i,
  input wire logic [1:0] ss_pm_req_i,
  input wire logic ss_gen2_able_i,
  input wire logic host_role_i,
  input wire logic [PORTS-1:0] dcd_contact_i,
  input wire uplm_pkg::uplm_wake_t wake_src_i,
  input wire logic wake_ack_i,
  output logic [PORTS-1:0][1:0] port_speed_o,
  output logic [PORTS-1:0] hs_unit_o,
  output logic [PORTS-1:0] fls_share_o,
  output logic [1:0] fls_users_o,
  output logic [PORTS-1:0][1:0] u2_pm_o,
  output logic [1:0] ss_pm_o,
  output logic ss_gen2_o,
  output logic ss_rev31_o,
  output logic [PORTS-1:0] dcd_done_o,
  output logic sched_native_o,
  output logic wake_req_o,
  output uplm_pkg::uplm_wake_t wake_cause_o
);
  // pin-side inputs pass three flops; change counts when 2nd and 3rd agree
  // skewed bits may show a brief in-between speed
  localparam int AW = $bits(uplm_pkg::uplm_attach_t) * PORTS;
  localparam int WW = $bits(uplm_pkg::uplm_wake_t);
  logic [AW-1:0] att_s1_reg, att_s2_reg, att_s3_reg, att_q_reg;
  logic [AW-1:0] att_q_next;
  logic [WW-1:0] wk_s1_reg, wk_s2_reg, wk_s3_reg;
  logic [PORTS-1:0] dc_s1_reg, dc_s2_reg, dc_s3_reg, dc_q_reg, dc_q_next;
  logic [AW-1:0] att_prev_reg;

  always_comb begin
    att_q_next = att_q_reg;
    for (int i = 0; i < AW; i++) begin
      if (att_s2_reg[i] == att_s3_reg[i]) begin
        att_q_next[i] = att_s3_reg[i];
      end
    end
    dc_q_next = dc_q_reg;
    for (int i = 0; i < PORTS; i++) begin
      if (dc_s2_reg[i] == dc_s3_reg[i]) begin
        dc_q_next[i] = dc_s3_reg[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      att_s1_reg <= '0;
      att_s2_reg <= '0;
      att_s3_reg <= '0;
      att_q_reg <= '0;
      att_prev_reg <= '0;
      wk_s1_reg <= '0;
      wk_s2_reg <= '0;
      wk_s3_reg <= '0;
      dc_s1_reg <= '0;
      dc_s2_reg <= '0;
      dc_s3_reg <= '0;
      dc_q_reg <= '0;
    end else if (ce_i) begin
      att_s1_reg <= attach_i;
      att_s2_reg <= att_s1_reg;
      att_s3_reg <= att_s2_reg;
      att_q_reg <= att_q_next;
      att_prev_reg <= att_q_reg;
      wk_s1_reg <= wake_src_i;
      wk_s2_reg <= wk_s1_reg;
      wk_s3_reg <= wk_s2_reg;
      dc_s1_reg <= dcd_contact_i;
      dc_s2_reg <= dc_s1_reg;
      dc_s3_reg <= dc_s2_reg;
      dc_q_reg <= dc_q_next;
    end
  end

  uplm_pkg::uplm_attach_t [PORTS-1:0] att_q, att_prev;
  assign att_q = att_q_reg;
  assign att_prev = att_prev_reg;

  // per-port speed, bandwidth and link power
  logic [PORTS-1:0][1:0] spd_reg, spd_next, lpm_reg, lpm_next;
  logic [PORTS-1:0] hs_reg, hs_next, fls_reg, fls_next;
  logic [PORTS-1:0] dcd_reg, dcd_next;
  logic [PORTS-1:0] conn_ev, disc_ev;

  genvar g;
  generate
    for (g = 0; g < PORTS; g++) begin : g_port
      assign conn_ev[g] = att_q[g].attached & ~att_prev[g].attached;
      assign disc_ev[g] = ~att_q[g].attached & att_prev[g].attached;
      always_comb begin
        spd_next[g] = uplm_pkg::UPLM_SPD_NONE;
        if (att_q[g].attached) begin
          if (att_q[g].is_usb2) begin
            spd_next[g] = uplm_pkg::UPLM_SPD_HS;
          end else if (att_q[g].low_speed) begin
            spd_next[g] = uplm_pkg::UPLM_SPD_LS;
          end else begin
            spd_next[g] = uplm_pkg::UPLM_SPD_FS;
          end
        end
        hs_next[g] = (spd_next[g] == uplm_pkg::UPLM_SPD_HS);
        fls_next[g] = (spd_next[g] == uplm_pkg::UPLM_SPD_LS) ||
                      (spd_next[g] == uplm_pkg::UPLM_SPD_FS);
        // detached port falls back to the active link state
        lpm_next[g] = uplm_pkg::UPLM_L0;
        if (att_q[g].attached) begin
          if (l2_suspend_req_i[g]) begin
            lpm_next[g] = uplm_pkg::UPLM_L2;
          end else if (l2_lpm_req_i[g]) begin
            lpm_next[g] = uplm_pkg::UPLM_L1;
          end
        end
        // charger contact detect sticks until detach
        dcd_next[g] = att_q[g].attached & (dcd_reg[g] | dc_q_reg[g]);
      end
    end
  endgenerate

  // users of the shared full/low-speed instance
  logic [1:0] fls_cnt;
  always_comb begin
    fls_cnt = '0;
    for (int i = 0; i < PORTS; i++) begin
      fls_cnt = fls_cnt + {1'b0, fls_next[i]};
    end
  end

  // superspeed: gen2 and 3.1 only as host, device stays at 3.0 gen1
  logic [1:0] ss_reg, ss_next;
  logic gen2_reg, gen2_next;
  logic rev31_reg, rev31_next;
  logic [1:0] flsu_reg;
  always_comb begin
    ss_next = ss_pm_req_i;
    rev31_next = 1'b0;
    gen2_next = 1'b0;
    if (host_role_i) begin
      rev31_next = 1'b1;
      gen2_next = ss_gen2_able_i;
    end
  end

  // wake: set wins over acknowledge
  logic wake_reg, wake_next;
  logic [WW-1:0] cause_reg, cause_next, ev;
  // level sources re-arm the wake for as long as they stay high
  // an acknowledge while ce_i is low is not seen
  always_comb begin
    ev = '0;
    ev[3] = wk_s3_reg[3] & wk_s2_reg[3];
    // pin reports of connect and disconnect add to the attach edges
    ev[2] = (|conn_ev) | (wk_s3_reg[2] & wk_s2_reg[2]);
    ev[1] = (|disc_ev) | (wk_s3_reg[1] & wk_s2_reg[1]);
    ev[0] = wk_s3_reg[0] & wk_s2_reg[0];
    cause_next = wake_ack_i ? ev : (cause_reg | ev);
    wake_next = (|ev) | (wake_reg & ~wake_ack_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spd_reg <= {PORTS{uplm_pkg::SPD_RST}};
      hs_reg <= '0;
      fls_reg <= '0;
      flsu_reg <= '0;
      lpm_reg <= '0;
      dcd_reg <= '0;
      ss_reg <= uplm_pkg::UPLM_U0;
      gen2_reg <= 1'b0;
      rev31_reg <= 1'b0;
      wake_reg <= 1'b0;
      cause_reg <= '0;
    end else if (ce_i) begin
      spd_reg <= spd_next;
      hs_reg <= hs_next;
      fls_reg <= fls_next;
      flsu_reg <= fls_cnt;
      lpm_reg <= lpm_next;
      dcd_reg <= dcd_next;
      ss_reg <= ss_next;
      gen2_reg <= gen2_next;
      rev31_reg <= rev31_next;
      wake_reg <= wake_next;
      cause_reg <= cause_next;
    end
  end
  assign port_speed_o = spd_reg;
  assign hs_unit_o = hs_reg;
  assign fls_share_o = fls_reg;
  assign fls_users_o = flsu_reg;
  assign u2_pm_o = lpm_reg;
  assign ss_pm_o = ss_reg;
  assign ss_gen2_o = gen2_reg;
  assign ss_rev31_o = rev31_reg;
  assign dcd_done_o = dcd_reg;
  assign sched_native_o = rev31_reg;
  assign wake_req_o = wake_reg;
  assign wake_cause_o = cause_reg;
endmodule

//--- sim/uplm_link_manager_asserts.sv
`timescale 1ns/1ps
module uplm_chk #(
  parameter int PORTS = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [PORTS-1:0] l2_suspend_req_i,
  input wire logic [1:0] ss_pm_req_i,
  input wire logic host_role_i,
  input wire uplm_pkg::uplm_wake_t wake_src_i,
  input wire logic wake_ack_i,
  input wire logic [PORTS-1:0][1:0] port_speed_o,
  input wire logic [PORTS-1:0] hs_unit_o,
  input wire logic [PORTS-1:0] fls_share_o,
  input wire logic [PORTS-1:0][1:0] u2_pm_o,
  input wire logic [1:0] ss_pm_o,
  input wire logic ss_rev31_o,
  input wire logic wake_req_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_hs_unit_own: assert property (
    hs_unit_o[0] == (port_speed_o[0] == 2'h3))
    else $error("hs unit not tied to speed");
  a_fls_shared: assert property (
    fls_share_o[1] == (port_speed_o[1] inside {2'h1, 2'h2}))
    else $error("shared bus flag wrong");
  a_l2_wins: assert property (
    ce_i && l2_suspend_req_i[1] |=>
    (port_speed_o[1] != 2'h0) == (u2_pm_o[1] == 2'h3))
    else $error("suspend not entered");
  a_l_detached: assert property (
    port_speed_o[2] == 2'h0 && $past(port_speed_o[2]) == 2'h0 |->
    u2_pm_o[2] == 2'h0)
    else $error("power state on detached port");
  a_ss_state_copy: assert property (
    ce_i |=> ss_pm_o == $past(ss_pm_req_i))
    else $error("ss state not followed");
  a_rev_host_only: assert property (
    ce_i |=> ss_rev31_o == $past(host_role_i))
    else $error("rev 3.1 outside host role");
  a_wake_prompt: assert property (
    $rose(wake_src_i.overcurrent) |-> ##[1:5] wake_req_o)
    else $error("overcurrent wake late");
  a_wake_held: assert property (
    wake_req_o && !wake_ack_i |=> wake_req_o)
    else $error("wake dropped before ack");
  c_wake: cover property ($rose(wake_req_o));
  c_l2: cover property (u2_pm_o[1] == 2'h3);
  c_rev: cover property (ss_rev31_o);
endmodule
bind uplm_link_manager uplm_chk #(.PORTS(PORTS)) u_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .ce_i(ce_i),
  .l2_suspend_req_i(l2_suspend_req_i),
  .ss_pm_req_i(ss_pm_req_i),
  .host_role_i(host_role_i),
  .wake_src_i(wake_src_i),
  .wake_ack_i(wake_ack_i),
  .port_speed_o(port_speed_o),
  .hs_unit_o(hs_unit_o),
  .fls_share_o(fls_share_o),
  .u2_pm_o(u2_pm_o),
  .ss_pm_o(ss_pm_o),
  .ss_rev31_o(ss_rev31_o),
  .wake_req_o(wake_req_o)
);

//--- sim/uplm_peer.sv
`timescale 1ns/1ps
module uplm_peer (
  input wire logic plug_i,
  input wire logic usb2_i,
  input wire logic ls_i,
  output uplm_pkg::uplm_attach_t attach_o,
  output logic dcd_o
);
  // cable skew, unrelated to the clock; unplugged reads all low
  assign #13 attach_o = {plug_i, plug_i & usb2_i, plug_i & ls_i};
  assign #29 dcd_o = plug_i;
endmodule

//--- sim/test_uplm_link_manager.sv
`timescale 1ns/1ps
module test_uplm_link_manager;
  logic clk_i = 0, rst_i = 1, ce_i = 1;
  logic [2:0] plug = 0, u2 = 0, ls = 0;
  logic [2:0] l2_lpm_req_i = 0, l2_suspend_req_i = 0;
  logic [1:0] ss_pm_req_i = 0;
  logic ss_gen2_able_i = 0, host_role_i = 0, wake_ack_i = 0;
  uplm_pkg::uplm_wake_t wake_src_i = '0;
  wire uplm_pkg::uplm_attach_t [2:0] attach_i;
  wire [2:0] dcd_contact_i;
  logic [2:0] hs_unit_o, fls_share_o, dcd_done_o;
  logic [2:0][1:0] port_speed_o, u2_pm_o;
  logic [1:0] fls_users_o, ss_pm_o;
  logic ss_gen2_o, ss_rev31_o, sched_native_o, wake_req_o;
  uplm_pkg::uplm_wake_t wake_cause_o;
  int err_total = 0, checks = 0;
  always #25 clk_i = ~clk_i;
  for (genvar p = 0; p < 3; p++) begin : g_peer
    uplm_peer pr (
      .plug_i(plug[p]),
      .usb2_i(u2[p]),
      .ls_i(ls[p]),
      .attach_o(attach_i[p]),
      .dcd_o(dcd_contact_i[p])
    );
  end
  uplm_link_manager DUT (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .attach_i(attach_i),
    .l2_lpm_req_i(l2_lpm_req_i),
    .l2_suspend_req_i(l2_suspend_req_i),
    .ss_pm_req_i(ss_pm_req_i),
    .ss_gen2_able_i(ss_gen2_able_i),
    .host_role_i(host_role_i),
    .dcd_contact_i(dcd_contact_i),
    .wake_src_i(wake_src_i),
    .wake_ack_i(wake_ack_i),
    .port_speed_o(port_speed_o),
    .hs_unit_o(hs_unit_o),
    .fls_share_o(fls_share_o),
    .fls_users_o(fls_users_o),
    .u2_pm_o(u2_pm_o),
    .ss_pm_o(ss_pm_o),
    .ss_gen2_o(ss_gen2_o),
    .ss_rev31_o(ss_rev31_o),
    .dcd_done_o(dcd_done_o),
    .sched_native_o(sched_native_o),
    .wake_req_o(wake_req_o),
    .wake_cause_o(wake_cause_o)
  );
  task cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task ack_wake;
    wake_ack_i = 1;
    cyc(1);
    wake_ack_i = 0;
    cyc(1);
    chk(wake_req_o, 8'h00);
  endtask
  task t_attach;
    plug = 3'h3;
    u2 = 3'h1;
    cyc(8);
    chk(port_speed_o, 8'h0B);
    chk(hs_unit_o, 8'h01);
    chk({fls_users_o, fls_share_o}, 8'h0A);
    chk(dcd_done_o, 8'h03);
    chk({wake_req_o, wake_cause_o}, 8'h14);
    ack_wake;
  endtask
  task t_lpm;
    l2_lpm_req_i = 3'h7;
    l2_suspend_req_i = 3'h2;
    cyc(2);
    chk(u2_pm_o, 8'h0D);
    l2_lpm_req_i = 0;
    l2_suspend_req_i = 0;
    cyc(2);
    chk(u2_pm_o, 8'h00);
  endtask
  task t_ss;
    for (int i = 0; i < 8; i++) begin
      ss_pm_req_i = i[1:0];
      host_role_i = i[2];
      ss_gen2_able_i = i[0];
      cyc(2);
      chk(ss_pm_o, i[1:0]);
      chk({ss_gen2_o, ss_rev31_o, sched_native_o},
          {i[2] & i[0], i[2], i[2]});
    end
  endtask
  task t_freeze;
    ce_i = 0;
    ss_pm_req_i = 2'h1;
    cyc(3);
    chk(ss_pm_o, 8'h03);
    ce_i = 1;
    cyc(1);
    chk(ss_pm_o, 8'h01);
  endtask
  task t_wake;
    plug = 3'h7;
    ls = 3'h4;
    cyc(8);
    chk({fls_users_o, port_speed_o}, 8'h9B);
    chk(wake_cause_o, 8'h04);
    ack_wake;
    wake_src_i = 4'hF;
    cyc(6);
    chk({wake_req_o, wake_cause_o}, 8'h1F);
    wake_src_i = '0;
    // let the synchroniser drain, or the level re-arms the wake
    cyc(4);
    ack_wake;
    plug = 3'h6;
    cyc(8);
    chk({wake_req_o, wake_cause_o, hs_unit_o}, 8'h90);
    chk(dcd_done_o, 8'h06);
  endtask
  task report_and_stop;
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    cyc(4);
    rst_i = 0;
    cyc(1);
    t_attach;
    t_lpm;
    t_ss;
    t_freeze;
    t_wake;
    report_and_stop;
  end
  initial begin
    #100000;
    err_total++;
    report_and_stop;
  end
endmodule
